// [dv/bus_master_model.sv]
`timescale 1ns/1ns
`default_nettype none
// two-wire master; 80 ns bit, scl stands high between frames
module bus_master_model (
  input wire logic clk,
  input wire logic sdaWire,
  output logic scl,
  output logic sdaDrv
);
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  // steps land on falling core edges, clear of the sampling edge
  task automatic go(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic start();
    sdaDrv = 1'b1;
    go(2);
    scl = 1'b1;
    go(2);
    sdaDrv = 1'b0;
    go(2);
    scl = 1'b0;
    go(2);
  endtask
  task automatic stop();
    sdaDrv = 1'b0;
    go(2);
    scl = 1'b1;
    go(2);
    sdaDrv = 1'b1;
    go(4);
  endtask
  // msb first, then the ninth clock reads the ack
  task automatic put(logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sdaDrv = b[i];
      go(2);
      scl = 1'b1;
      go(4);
      scl = 1'b0;
      go(2);
    end
    sdaDrv = 1'b1;
    go(2);
    scl = 1'b1;
    go(2);
    ack = !sdaWire;
    go(2);
    scl = 1'b0;
    go(2);
  endtask
endmodule // bus_master_model
`default_nettype wire

// [dv/gamma_dac_latch_control_properties.sv]
`timescale 1ns/1ns
`default_nettype none
// bus and latch timing, watched from the top ports only
module gamma_dac_latch_control_properties import gamma_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe_n,
  input wire logic outputLatchPin,
  input wire logic [CHAN_COUNT-1:0][CODE_W-1:0] chanCode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // with the latch pin steady, outputs only move just after a bus byte ends, so scl was low
  a_reset_mid: assert property (
    $rose(rst_n) |-> chanCode == {CHAN_COUNT{DEFAULT_CODE}})
    else $error("outputs not mid-level after reset");
  a_held_quiet: assert property (
    outputLatchPin[*6] ##0 $changed(chanCode) |-> !$past(sclIn, 2))
    else $error("output moved while latch held");
  a_direct_byte: assert property (
    (!outputLatchPin)[*6] ##0 $changed(chanCode) |-> !$past(sclIn, 2))
    else $error("direct update off a byte end");
  a_latch_synced: assert property (
    $fell(outputLatchPin) |-> $stable(chanCode) ##1 $stable(chanCode))
    else $error("latch pin used before sync");
  a_ack_in_low: assert property (
    $fell(sdaOe_n) |-> !sclIn && !sdaOut)
    else $error("ack started with scl high");
  a_ack_stands: assert property (
    $fell(sdaOe_n) |-> (!sdaOe_n)[*6])
    else $error("ack too short");
  a_release_low: assert property (
    $rose(sdaOe_n) |-> !sclIn)
    else $error("ack released with scl high");
  a_start_quiet: assert property (
    sclIn && $fell(sdaIn) |-> sdaOe_n[*8])
    else $error("drive right after start");
endmodule // gamma_dac_latch_control_properties

bind gamma_dac_latch_control gamma_dac_latch_control_properties i_props (
  .core_clk(core_clk), .rst_n(rst_n), .sclIn(sclIn), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .outputLatchPin(outputLatchPin),
  .chanCode(chanCode));
`default_nettype wire

// [dv/gamma_dac_latch_control_tb.sv]
`timescale 1ns/1ns
`default_nettype none
// writes channels over the bus and checks the output codes
module gamma_dac_latch_control_tb import gamma_pkg::*;;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic latchPin = 1'b0;
  logic scl;
  logic sdaDrv;
  logic sdaOut;
  logic sdaOe_n;
  logic [CHAN_COUNT-1:0][CODE_W-1:0] code;
  int n_fail = 0;
  int n_checks = 0;
  // open-drain wire: pulled up, low if either side pulls
  wire logic sdaWire = sdaDrv & (sdaOe_n | sdaOut);
  always #5 core_clk = ~core_clk;
  gamma_dac_latch_control i_dut (.core_clk(core_clk), .rst_n(rst_n),
    .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n),
    .outputLatchPin(latchPin), .chanCode(code));
  bus_master_model i_mst (.clk(core_clk), .sdaWire(sdaWire), .scl(scl),
    .sdaDrv(sdaDrv));
  task automatic chk(string what, logic [9:0] seen, logic [9:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // one frame of n bytes; gives up after the first refused byte
  task automatic frame(logic [31:0] b, int n, logic [3:0] exp);
    logic [3:0] acks;
    logic a;
    acks = 4'h0;
    i_mst.start();
    for (int i = 0; i < n; i++) begin
      i_mst.put(b[31-8*i -: 8], a);
      acks[3-i] = a;
      if (!a) break;
    end
    i_mst.stop();
    chk("ack", {6'h00, acks}, {6'h00, exp});
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // a hang is cut short and counted as a mismatch; a clean run needs
  // just under a fifth of this limit
  initial begin
    #200000;
    n_fail++;
    end_sim();
  end
  initial begin
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    for (int c = 0; c < CHAN_COUNT; c++) chk("rst", code[c], 10'h200);
    frame(32'h7405_0234, 4, 4'hF);
    chk("direct", code[5], 10'h234);
    frame(32'h7413_03FF, 4, 4'hF);
    chk("com2", code[19], 10'h3FF);
    chk("com1", code[18], 10'h200);
    frame(32'h7414_0000, 4, 4'h8);
    frame(32'h7600_0000, 1, 4'h0);
    frame(32'h7403_0100, 3, 4'hE);
    chk("early", code[3], 10'h200);
    $display("test direct over");
    latchPin = 1'b1;
    frame(32'h7400_0155, 4, 4'hF);
    chk("held", code[0], 10'h200);
    latchPin = 1'b0;
    repeat (6) @(negedge core_clk);
    chk("fall", code[0], 10'h155);
    latchPin = 1'b1;
    frame(32'h7401_00AA, 4, 4'hF);
    frame(32'h7402_8111, 4, 4'hF);
    chk("soft1", code[1], 10'h0AA);
    chk("soft2", code[2], 10'h111);
    $display("test latch over");
    latchPin = 1'b0;
    frame(32'h7445_0000, 4, 4'hF);
    chk("one", code[5], 10'h200);
    chk("other", code[19], 10'h3FF);
    frame(32'h7493_0000, 4, 4'hF);
    chk("all", code[0], 10'h200);
    frame(32'h7406_0321, 4, 4'hF);
    latchPin = 1'b1;
    frame(32'h0007_0000, 2, 4'h8);
    chk("gc bad", code[6], 10'h321);
    frame(32'h0006_0000, 2, 4'hC);
    chk("gc", code[6], 10'h200);
    // a second power-up reset in mid-run must clear a written channel
    latchPin = 1'b0;
    frame(32'h7407_0123, 4, 4'hF);
    chk("pre rst", code[7], 10'h123);
    rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    chk("rst mid", code[7], 10'h200);
    $display("test reset over");
    end_sim();
  end
endmodule // gamma_dac_latch_control_tb
`default_nettype wire

// [rtl/bank_if.sv]
`timescale 1ns/1ns
`default_nettype none
// control strobes from the bus engine into the channel bank
interface bank_if;
  logic wrEn;
  logic [4:0] chan;
  logic [9:0] code;
  logic latchAll;
  logic directMode;
  logic resetAll;
  logic resetOne;
  modport ctrl (
    output wrEn, chan, code, latchAll, directMode, resetAll, resetOne
  );
  modport bank (
    input wrEn, chan, code, latchAll, directMode, resetAll, resetOne
  );
endinterface
`default_nettype wire

// [rtl/dac_bank.sv]
`timescale 1ns/1ns
`default_nettype none
// storage and output registers, one pair per channel
module dac_bank import gamma_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  bank_if.bank bif,
  output logic [CHAN_COUNT-1:0][CODE_W-1:0] outCode
);
  logic [CODE_W-1:0] store_q [CHAN_COUNT];
  logic [CODE_W-1:0] out_q [CHAN_COUNT];

  generate
    for (genvar g = 0; g < CHAN_COUNT; g++) begin : g_chan
      logic hit;
      logic rstHit;
      logic [CODE_W-1:0] store_d;
      logic [CODE_W-1:0] out_d;
      // each channel decodes its own index, so the two common-voltage
      // channels never couple with the gamma ones
      assign hit = bif.wrEn && (bif.chan == 5'(g));
      assign rstHit = bif.resetAll ||
        (bif.resetOne && (bif.chan == 5'(g)));
      assign store_d = rstHit ? DEFAULT_CODE :
        (hit ? bif.code : store_q[g]);
      // a latch-all in the same cycle as a write carries that write
      assign out_d = rstHit ? DEFAULT_CODE :
        bif.latchAll ? store_d :
        (hit && bif.directMode) ? bif.code : out_q[g];
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          store_q[g] <= DEFAULT_CODE;
          out_q[g] <= DEFAULT_CODE;
        end else begin
          store_q[g] <= store_d;
          out_q[g] <= out_d;
        end
      end
      assign outCode[g] = out_q[g];
    end
  endgenerate
endmodule // dac_bank
`default_nettype wire

// [rtl/gamma_dac_latch_control.sv]
`timescale 1ns/1ns
`default_nettype none
// two-wire slave front end and latch control for the channel bank;
// the analog stage turns each chanCode into lref + code*(href-lref)/1024
module gamma_dac_latch_control import gamma_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe_n,
  input wire logic outputLatchPin,
  output logic [CHAN_COUNT-1:0][CODE_W-1:0] chanCode
);
  logic [2:0] syncLvl;
  logic [2:0] prevLvl;
  phase_t phase_q, phase_d;
  logic [3:0] bitCnt_q;
  logic ackSlot_q;
  logic [7:0] shift_q;
  logic [7:0] msb_q;
  logic [4:0] chan_q;
  logic rstPend_q;
  logic rstOne_q;
  logic sdaOe_n_q;
  logic sdaOut_q;
  bank_if bif ();

  pin_front #(.W(3)) u_front (
    .clk(core_clk),
    .rst_n(rst_n),
    .rawIn({outputLatchPin, sdaIn, sclIn}),
    .syncQ(syncLvl),
    .prevQ(prevLvl)
  );

  dac_bank u_bank (
    .clk(core_clk),
    .rst_n(rst_n),
    .bif(bif),
    .outCode(chanCode)
  );

  // bus events, all from synchronised levels
  wire sclRise = syncLvl[0] & ~prevLvl[0];
  wire sclFall = ~syncLvl[0] & prevLvl[0];
  wire sdaLvl = syncLvl[1];
  wire busStart = syncLvl[0] & prevLvl[0] & prevLvl[1] & ~syncLvl[1];
  wire busStop = syncLvl[0] & prevLvl[0] & ~prevLvl[1] & syncLvl[1];
  wire latchHigh = syncLvl[2];
  wire latchFall = prevLvl[2] & ~syncLvl[2];

  // byte decode
  wire byteDone = sclFall & ~ackSlot_q & (bitCnt_q == BITS_PER_BYTE);
  wire addrIsDev = (shift_q == DEV_ADDR_BYTE);
  wire addrIsGc = (shift_q == GC_ADDR);
  wire gcIsReset = (shift_q == GC_RESET);
  wire [2:0] prefix = shift_q[7:5];
  wire chanOk = (shift_q[4:0] <= CHAN_LAST);
  wire prefixOk = (prefix == PREFIX_WRITE) || (prefix == PREFIX_RST_ALL) ||
    (prefix == PREFIX_RST_ONE);
  wire inAddr = (phase_q == PH_ADDR);
  wire inChan = (phase_q == PH_CHAN);
  wire inMsb = (phase_q == PH_MSB);
  wire inLsb = (phase_q == PH_LSB);
  wire inGc = (phase_q == PH_GCDATA);
  wire ackNow = (inAddr & (addrIsDev | addrIsGc)) |
    (inChan & chanOk & prefixOk) | inMsb | inLsb | (inGc & gcIsReset);

  // next protocol phase after a whole byte; reads are not served
  always_comb begin
    phase_d = phase_q;
    unique case (phase_q)
      PH_IDLE: phase_d = PH_IDLE;
      PH_ADDR: phase_d = addrIsDev ? PH_CHAN :
        (addrIsGc ? PH_GCDATA : PH_IGNORE);
      PH_CHAN: phase_d = (chanOk & prefixOk) ? PH_MSB : PH_IGNORE;
      PH_MSB: phase_d = PH_LSB;
      PH_LSB: phase_d = PH_CHAN;
      PH_GCDATA: phase_d = PH_IGNORE;
      PH_IGNORE: phase_d = PH_IGNORE;
    endcase
  end

  // strobes into the bank; only a finished low byte raises wrEn
  assign bif.wrEn = byteDone & inLsb & ~rstPend_q;
  assign bif.chan = chan_q;
  assign bif.code = {msb_q[1:0], shift_q};
  assign bif.directMode = ~latchHigh;
  assign bif.latchAll = latchFall |
    (byteDone & inLsb & ~rstPend_q & msb_q[LATCH_BIT] & latchHigh);
  assign bif.resetAll =
    (byteDone & inChan & chanOk & (prefix == PREFIX_RST_ALL)) |
    (byteDone & inGc & gcIsReset);
  assign bif.resetOne = byteDone & inLsb & rstPend_q & rstOne_q;

  // phase, bit counter and acknowledge slot
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= PH_IDLE;
      bitCnt_q <= 4'h0;
      ackSlot_q <= 1'b0;
      sdaOe_n_q <= 1'b1;
    end else if (busStart) begin
      phase_q <= PH_ADDR; // repeated start also aborts a half word
      bitCnt_q <= 4'h0;
      ackSlot_q <= 1'b0;
      sdaOe_n_q <= 1'b1;
    end else if (busStop) begin
      phase_q <= PH_IDLE;
      bitCnt_q <= 4'h0;
      ackSlot_q <= 1'b0;
      sdaOe_n_q <= 1'b1;
    end else if (byteDone) begin
      phase_q <= phase_d;
      bitCnt_q <= 4'h0;
      ackSlot_q <= 1'b1;
      sdaOe_n_q <= ~ackNow;
    end else if (sclFall & ackSlot_q) begin
      ackSlot_q <= 1'b0;
      sdaOe_n_q <= 1'b1; // release after the ninth clock
    end else if (sclRise & ~ackSlot_q & (phase_q != PH_IDLE) &
                 (bitCnt_q != BITS_PER_BYTE)) begin
      bitCnt_q <= bitCnt_q + 4'h1;
    end
  end

  // data path: shifter and captured fields
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= 8'h00;
      msb_q <= 8'h00;
      chan_q <= 5'h00;
      rstPend_q <= 1'b0;
      rstOne_q <= 1'b0;
    end else begin
      if (sclRise & ~ackSlot_q) begin
        shift_q <= {shift_q[6:0], sdaLvl};
      end
      if (byteDone & inChan) begin
        chan_q <= shift_q[4:0];
        rstPend_q <= (prefix != PREFIX_WRITE);
        rstOne_q <= (prefix == PREFIX_RST_ONE);
      end
      if (byteDone & inMsb) begin
        msb_q <= shift_q;
      end
    end
  end

  // the pin only ever pulls low, its data level never changes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sdaOut_q <= 1'b0;
    end else begin
      sdaOut_q <= 1'b0;
    end
  end

  assign sdaOe_n = sdaOe_n_q;
  assign sdaOut = sdaOut_q;
endmodule // gamma_dac_latch_control
`default_nettype wire

// [rtl/gamma_pkg.sv]
// Notes on behaviour
// - twenty channels, eighteen gamma plus two common-voltage, each a ten-bit code.
// - analog level is low ref plus code times span over 1024.
// - general-call address byte 00h is always acknowledged.
// - general-call data 06h is acknowledged, then a full reset follows.
// - other general-call data bytes are not acknowledged and reset nothing.
// - power-up reset puts every channel at the mid-level default code.
// - channel byte with prefix 100 and valid channel resets all channels.
// - prefix 010 resets only the addressed channel after its two data bytes.
// - each channel has a storage register and a separate output register.
// - latch pin low, each storage write passes straight to its output.
// - latch pin high holds outputs; its falling edge updates all together. Prefix 100 and 010 resets still load outputs while the latch pin is high.
// - latch high, bit 15 set updates all outputs after the low byte.
// - general-call and power-up resets load outputs whatever the latch pin.
// - common-voltage channels are written independently of gamma channels.
// - device answers at address byte 74h.
// - channel number in low five bits; only 0 to 19 acknowledged.
// - value sent high byte first, two code bits in it; store after low.
// - stop or start before the low byte leaves storage untouched.
`default_nettype none
package gamma_pkg;
  localparam int CHAN_COUNT = 20;
  localparam int CODE_W = 10;
  localparam logic [9:0] DEFAULT_CODE = 10'h200; // (href - lref)/2 point
  localparam logic [7:0] DEV_ADDR_BYTE = 8'h74; // write address, r/w bit 0
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [7:0] GC_RESET = 8'h06;
  localparam logic [4:0] CHAN_LAST = 5'h13;
  localparam logic [2:0] PREFIX_WRITE = 3'h0;
  localparam logic [2:0] PREFIX_RST_ALL = 3'h4;
  localparam logic [2:0] PREFIX_RST_ONE = 3'h2;
  localparam int LATCH_BIT = 7; // bit 15 of the word, bit 7 of high byte
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_ADDR = 3'b001,
    PH_CHAN = 3'b011,
    PH_MSB = 3'b010,
    PH_LSB = 3'b110,
    PH_GCDATA = 3'b111,
    PH_IGNORE = 3'b101
  } phase_t;
endpackage
`default_nettype wire

// [rtl/pin_front.sv]
`timescale 1ns/1ns
`default_nettype none
// two-flop synchronisers plus one history stage for edge finding
module pin_front #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] rawIn,
  output logic [W-1:0] syncQ,
  output logic [W-1:0] prevQ
);
  logic [W-1:0] meta_q;

  // idle bus and idle latch pin are high, so reset to ones
  generate
    for (genvar i = 0; i < W; i++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q[i] <= 1'b1;
          syncQ[i] <= 1'b1;
          prevQ[i] <= 1'b1;
        end else begin
          meta_q[i] <= rawIn[i];
          syncQ[i] <= meta_q[i];
          prevQ[i] <= syncQ[i];
        end
      end
    end
  endgenerate
endmodule // pin_front
`default_nettype wire
